// file: design/brw_defines.svh
/*
 Timing counts, offsets and reset values for the board reset and watchdog block.
 Assumes a 125 MHz clock; included by its bare name.
*/
`ifndef BRW_DEFINES_SVH
`define BRW_DEFINES_SVH

`define BRW_CLK_PERIOD_NS 8
`define BRW_WD_TIMEOUT_MS 1000
`define BRW_WD_TIMEOUT_CYC (`BRW_WD_TIMEOUT_MS * 1000000 / `BRW_CLK_PERIOD_NS)
`define BRW_RST_HOLD_US 100
`define BRW_RST_HOLD_CYC ((`BRW_RST_HOLD_US * 1000 + `BRW_CLK_PERIOD_NS - 1) / `BRW_CLK_PERIOD_NS)
`define BRW_WD_PULSE_US 10
`define BRW_WD_PULSE_CYC ((`BRW_WD_PULSE_US * 1000 + `BRW_CLK_PERIOD_NS - 1) / `BRW_CLK_PERIOD_NS)
`define BRW_DEB_US 1000
`define BRW_DEB_CYC ((`BRW_DEB_US * 1000 + `BRW_CLK_PERIOD_NS - 1) / `BRW_CLK_PERIOD_NS)

`define BRW_ADDR_CTRL 4'h0
`define BRW_ADDR_KICK 4'h1
`define BRW_ADDR_STATUS 4'h2
`define BRW_ADDR_IRQ_STAT 4'h3
`define BRW_ADDR_IRQ_MASK 4'h4

`define BRW_KICK_KEY 8'ha5
`define BRW_CTRL_RST 2'h0
`define BRW_IRQ_MASK_RST 4'h0

`define BRW_EV_POR 0
`define BRW_EV_BTN 1
`define BRW_EV_WD 2
`define BRW_EV_CPU 3

`endif

// file: design/brw_pkg.sv
/*
 Types for the board reset and watchdog block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package brw_pkg;
    typedef enum logic [1:0] {
        BRW_SEQ_HOLD,
        BRW_SEQ_RUN
    } brw_seq_t;
    typedef logic [3:0] brw_ev_t;
endpackage

// file: design/brw_sync_if.sv
/*
 Interface carrying the synchronised pin levels from the input stage to the core.
 Assumes both ends run on mclk_i.
*/
`timescale 1ns/100ps
interface brw_sync_if;
    logic power_good;
    logic button_pressed;
    modport src (output power_good, output button_pressed);
    modport dst (input power_good, input button_pressed);
endinterface

// file: design/brw_pin_sync.sv
/*
 Two-stage synchronisers and a button debouncer for the pin inputs.
 Assumes asynchronous pins; the button pin is active low.
*/
`timescale 1ns/100ps
`include "brw_defines.svh"
module brw_pin_sync
    import brw_pkg::*;
#(
    parameter int DEB_CYC = `BRW_DEB_CYC
) (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic power_good_i,
    input wire logic reset_button_n_i,
    brw_sync_if.src sync
);
    logic [1:0] pg_sync_reg;
    logic [1:0] btn_sync_reg;
    logic btn_stable_reg;
    logic [17:0] deb_cnt_reg;

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            pg_sync_reg <= 2'h0;
            btn_sync_reg <= 2'h0;
        end else begin
            pg_sync_reg <= {pg_sync_reg[0], power_good_i};
            btn_sync_reg <= {btn_sync_reg[0], ~reset_button_n_i};
        end
    end

    // The pressed level must stay steady for the debounce time before it is accepted.
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            btn_stable_reg <= 1'b0;
            deb_cnt_reg <= 18'h0;
        end else if (btn_sync_reg[1] == btn_stable_reg) begin
            deb_cnt_reg <= 18'h0;
        end else if (deb_cnt_reg >= 18'(DEB_CYC - 1)) begin
            btn_stable_reg <= btn_sync_reg[1];
            deb_cnt_reg <= 18'h0;
        end else begin
            deb_cnt_reg <= deb_cnt_reg + 18'h1;
        end
    end

    assign sync.power_good = pg_sync_reg[1];
    assign sync.button_pressed = btn_stable_reg;
endmodule

// file: design/brw_top.sv
/*
 Board reset combiner and watchdog with register port, indicators and interrupt.
 Assumes pins are asynchronous to mclk_i and the processor uses the plain register port.
*/
// Notes on behaviour
// - Reset at power-on and on supply drop.
// - Reset while push button is pressed.
// - Watchdog expiry resets the board.
// - CPU reset instruction resets peripherals only.
// - CPU reset instruction never resets the processor.
// - Watchdog release pulses reset, lights red indicator.
// - Watchdog release pulses readable status flag.
// - Yellow indicator lit while processor reports OK.
// - Button reset reaches computer, modem, radio boards.
`timescale 1ns/100ps
`include "brw_defines.svh"
module brw_top
    import brw_pkg::*;
#(
    parameter int WD_TIMEOUT_CYC = `BRW_WD_TIMEOUT_CYC,
    parameter int RST_HOLD_CYC = `BRW_RST_HOLD_CYC,
    parameter int WD_PULSE_CYC = `BRW_WD_PULSE_CYC,
    parameter int DEB_CYC = `BRW_DEB_CYC
) (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic power_good_i,
    input wire logic reset_button_n_i,
    input wire logic cpu_reset_instr_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    output logic cpu_core_rst_o,
    output logic computer_board_rst_o,
    output logic line_modem_board_rst_o,
    output logic radio_board_rst_o,
    output logic status_led_o,
    output logic wd_alarm_led_o,
    output logic watchdog_status_flag_o,
    output logic irq_o
);
    brw_sync_if sync ();

    brw_pin_sync #(
        .DEB_CYC(DEB_CYC)
    ) u_sync (
        .mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i),
        .power_good_i(power_good_i),
        .reset_button_n_i(reset_button_n_i),
        .sync(sync)
    );

    logic [1:0] ctrl_reg;
    logic [31:0] wd_cnt_reg;
    logic wd_fire;
    logic [15:0] wd_pulse_cnt_reg;
    logic wd_pulse_active;
    logic wd_alarm_reg;
    logic wdflag_reg;
    logic [1:0] cpu_sync_reg;
    logic cpu_prev_reg;
    logic cpu_rise;
    brw_seq_t full_state_reg;
    logic [15:0] full_cnt_reg;
    logic [15:0] per_cnt_reg;
    logic full_src;
    logic per_src;
    logic full_rst_reg;
    logic per_rst_reg;
    brw_ev_t irq_stat_reg;
    brw_ev_t irq_mask_reg;
    brw_ev_t events;
    logic pg_prev_reg;
    logic btn_prev_reg;
    logic kick_wr;
    logic [7:0] rdata_next;

    assign kick_wr = wr_i && (addr_i == `BRW_ADDR_KICK) && (wdata_i == `BRW_KICK_KEY);

    // Control bits: bit 0 processor OK, bit 1 watchdog enable.
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i || full_rst_reg) begin
            ctrl_reg <= `BRW_CTRL_RST;
        end else if (wr_i && addr_i == `BRW_ADDR_CTRL) begin
            ctrl_reg <= wdata_i[1:0];
        end
    end

    // Counter is held clear while disabled or in reset, and restarts on each kick.
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i || full_rst_reg || !ctrl_reg[1]) begin
            wd_cnt_reg <= 32'h0;
        end else if (kick_wr) begin
            wd_cnt_reg <= 32'h0;
        end else if (!wd_fire) begin
            wd_cnt_reg <= wd_cnt_reg + 32'h1;
        end
    end

    assign wd_fire = ctrl_reg[1] && !full_rst_reg &&
                     (wd_cnt_reg >= 32'(WD_TIMEOUT_CYC - 1));

    // A watchdog release produces a fixed-length pulse that feeds the reset combiner.
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            wd_pulse_cnt_reg <= 16'h0;
        end else if (wd_fire && wd_pulse_cnt_reg == 16'h0) begin
            wd_pulse_cnt_reg <= 16'(WD_PULSE_CYC);
        end else if (wd_pulse_cnt_reg != 16'h0) begin
            wd_pulse_cnt_reg <= wd_pulse_cnt_reg - 16'h1;
        end
    end

    assign wd_pulse_active = (wd_pulse_cnt_reg != 16'h0);

    // The red indicator stays lit until power cycling or an explicit clear by write.
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i || !sync.power_good) begin
            wd_alarm_reg <= 1'b0;
        end else if (wd_fire) begin
            wd_alarm_reg <= 1'b1;
        end else if (wr_i && addr_i == `BRW_ADDR_STATUS && wdata_i[0]) begin
            wd_alarm_reg <= 1'b0;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            wdflag_reg <= 1'b0;
        end else begin
            wdflag_reg <= wd_pulse_active;
        end
    end

    // The reset instruction line is synchronised and turned into a one-cycle event.
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            cpu_sync_reg <= 2'h0;
            cpu_prev_reg <= 1'b0;
        end else begin
            cpu_sync_reg <= {cpu_sync_reg[0], cpu_reset_instr_i};
            cpu_prev_reg <= cpu_sync_reg[1];
        end
    end

    assign cpu_rise = cpu_sync_reg[1] && !cpu_prev_reg;

    assign full_src = !sync.power_good || sync.button_pressed || wd_pulse_active;
    assign per_src = full_src || cpu_rise;

    // Full reset holds for the minimum time after the last source releases.
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            full_state_reg <= BRW_SEQ_HOLD;
            full_cnt_reg <= 16'h0;
        end else begin
            case (full_state_reg)
                BRW_SEQ_HOLD: begin
                    if (full_src) begin
                        full_cnt_reg <= 16'h0;
                    end else if (full_cnt_reg >= 16'(RST_HOLD_CYC - 1)) begin
                        full_state_reg <= BRW_SEQ_RUN;
                    end else begin
                        full_cnt_reg <= full_cnt_reg + 16'h1;
                    end
                end
                BRW_SEQ_RUN: begin
                    if (full_src) begin
                        full_state_reg <= BRW_SEQ_HOLD;
                        full_cnt_reg <= 16'h0;
                    end
                end
                default: begin
                    full_state_reg <= BRW_SEQ_HOLD;
                end
            endcase
        end
    end

    // Peripheral reset follows the same hold time and also honours the reset instruction.
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i || per_src) begin
            per_cnt_reg <= 16'h0;
        end else if (per_cnt_reg < 16'(RST_HOLD_CYC)) begin
            per_cnt_reg <= per_cnt_reg + 16'h1;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            full_rst_reg <= 1'b1;
        end else begin
            full_rst_reg <= (full_state_reg == BRW_SEQ_HOLD) || full_src;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            per_rst_reg <= 1'b1;
        end else begin
            per_rst_reg <= per_src || (per_cnt_reg < 16'(RST_HOLD_CYC));
        end
    end

    // The core reset sees only full-board sources, never the reset instruction.
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            cpu_core_rst_o <= 1'b1;
        end else begin
            cpu_core_rst_o <= full_rst_reg;
        end
    end

    // The three board resets share one source, so they always move together.
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            computer_board_rst_o <= 1'b1;
        end else begin
            computer_board_rst_o <= per_rst_reg;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            line_modem_board_rst_o <= 1'b1;
        end else begin
            line_modem_board_rst_o <= per_rst_reg;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            radio_board_rst_o <= 1'b1;
        end else begin
            radio_board_rst_o <= per_rst_reg;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            status_led_o <= 1'b0;
        end else begin
            status_led_o <= ctrl_reg[0] && !full_rst_reg;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            wd_alarm_led_o <= 1'b0;
        end else begin
            wd_alarm_led_o <= wd_alarm_reg;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            watchdog_status_flag_o <= 1'b0;
        end else begin
            watchdog_status_flag_o <= wdflag_reg;
        end
    end

    // Previous levels give the edge events for the interrupt status.
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            pg_prev_reg <= 1'b0;
        end else begin
            pg_prev_reg <= sync.power_good;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            btn_prev_reg <= 1'b0;
        end else begin
            btn_prev_reg <= sync.button_pressed;
        end
    end

    always_comb begin
        events = 4'h0;
        events[`BRW_EV_POR] = pg_prev_reg && !sync.power_good;
        events[`BRW_EV_BTN] = sync.button_pressed && !btn_prev_reg;
        events[`BRW_EV_WD] = wd_fire && !wd_pulse_active;
        events[`BRW_EV_CPU] = cpu_rise;
    end

    // Status bits are write-one-to-clear, and a new event wins over a clear.
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            irq_stat_reg <= 4'h0;
        end else if (wr_i && addr_i == `BRW_ADDR_IRQ_STAT) begin
            irq_stat_reg <= (irq_stat_reg & ~wdata_i[3:0]) | events;
        end else begin
            irq_stat_reg <= irq_stat_reg | events;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            irq_mask_reg <= `BRW_IRQ_MASK_RST;
        end else if (wr_i && addr_i == `BRW_ADDR_IRQ_MASK) begin
            irq_mask_reg <= wdata_i[3:0];
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    // Read data stand for the one cycle after the strobe and are zero otherwise.
    always_comb begin
        rdata_next = 8'h0;
        if (addr_i == `BRW_ADDR_CTRL) begin
            rdata_next = {6'h0, ctrl_reg};
        end else if (addr_i == `BRW_ADDR_STATUS) begin
            rdata_next = {3'h0, sync.button_pressed, sync.power_good,
                          wd_pulse_active, wdflag_reg, wd_alarm_reg};
        end else if (addr_i == `BRW_ADDR_IRQ_STAT) begin
            rdata_next = {4'h0, irq_stat_reg};
        end else if (addr_i == `BRW_ADDR_IRQ_MASK) begin
            rdata_next = {4'h0, irq_mask_reg};
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            rdata_o <= 8'h0;
        end else if (rd_i) begin
            rdata_o <= rdata_next;
        end else begin
            rdata_o <= 8'h0;
        end
    end
endmodule

// file: dv/brw_top_props.sv
/*
 Concurrent checks on the board reset and watchdog block's top ports.
 Assumes one clock, mclk_i, and the synchronous reset sys_rst_i.
*/
`timescale 1ns/100ps
module brw_top_props #(
    parameter int RST_HOLD_CYC = 16,
    parameter int WD_PULSE_CYC = 4
) (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic power_good_i,
    input wire logic reset_button_n_i,
    input wire logic cpu_core_rst_o,
    input wire logic computer_board_rst_o,
    input wire logic line_modem_board_rst_o,
    input wire logic radio_board_rst_o,
    input wire logic status_led_o,
    input wire logic wd_alarm_led_o,
    input wire logic watchdog_status_flag_o
);
    logic [15:0] hold_cnt_reg;
    logic [15:0] flag_cnt_reg;
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (sys_rst_i);
    // Counts how long the board reset and the status flag have stood high.
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i || !computer_board_rst_o) begin
            hold_cnt_reg <= 16'h0;
        end else if (hold_cnt_reg != 16'hffff) begin
            hold_cnt_reg <= hold_cnt_reg + 16'h1;
        end
    end
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i || !watchdog_status_flag_o) begin
            flag_cnt_reg <= 16'h0;
        end else begin
            flag_cnt_reg <= flag_cnt_reg + 16'h1;
        end
    end
    boards_agree_a: assert property (
        computer_board_rst_o == line_modem_board_rst_o && computer_board_rst_o == radio_board_rst_o)
        else $error("board resets differ");
    core_in_board_a: assert property (cpu_core_rst_o |-> computer_board_rst_o)
        else $error("core reset without board reset");
    power_drop_a: assert property ($fell(power_good_i) |-> ##[1:6] cpu_core_rst_o)
        else $error("no reset after supply drop");
    button_reset_a: assert property (!reset_button_n_i [*8] |-> ##[0:6] cpu_core_rst_o)
        else $error("no reset while button pressed");
    flag_length_a: assert property (
        $fell(watchdog_status_flag_o) |-> flag_cnt_reg == WD_PULSE_CYC)
        else $error("status flag pulse length wrong");
    flag_led_a: assert property ($rose(watchdog_status_flag_o) |-> wd_alarm_led_o)
        else $error("red indicator off at watchdog event");
    wd_reset_a: assert property ($rose(watchdog_status_flag_o) |-> ##[0:2] cpu_core_rst_o)
        else $error("no reset after watchdog expiry");
    led_off_a: assert property (cpu_core_rst_o [*3] |-> !status_led_o)
        else $error("yellow indicator lit in reset");
    hold_min_a: assert property (
        $fell(computer_board_rst_o) |-> hold_cnt_reg >= RST_HOLD_CYC)
        else $error("board reset released too early");
    cover property ($rose(watchdog_status_flag_o));
    cover property ($fell(power_good_i));
    cover property (computer_board_rst_o && !cpu_core_rst_o);
endmodule

bind brw_top brw_top_props #(
    .RST_HOLD_CYC(RST_HOLD_CYC),
    .WD_PULSE_CYC(WD_PULSE_CYC)
) u_props (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .power_good_i(power_good_i),
    .reset_button_n_i(reset_button_n_i),
    .cpu_core_rst_o(cpu_core_rst_o),
    .computer_board_rst_o(computer_board_rst_o),
    .line_modem_board_rst_o(line_modem_board_rst_o),
    .radio_board_rst_o(radio_board_rst_o),
    .status_led_o(status_led_o),
    .wd_alarm_led_o(wd_alarm_led_o),
    .watchdog_status_flag_o(watchdog_status_flag_o)
);

// file: dv/brw_partner.sv
/*
 Model of the push button and the processor's reset instruction line.
 Assumes commands from the bench on mclk_i.
*/
`timescale 1ns/100ps
module brw_partner (
    input wire logic mclk_i,
    input wire logic press_i,
    input wire logic instr_i,
    output logic reset_button_n_o = 1'b1,
    output logic cpu_reset_instr_o = 1'b0
);
    logic [2:0] hist_reg = 3'h0;
    // Contacts chatter for a few cycles after each change of the button.
    always_ff @(posedge mclk_i) begin
        hist_reg <= {hist_reg[1:0], press_i};
        if (press_i != hist_reg[2]) begin
            reset_button_n_o <= hist_reg[0] ^ hist_reg[1];
        end else begin
            reset_button_n_o <= !press_i;
        end
    end
    always_ff @(posedge mclk_i) begin
        cpu_reset_instr_o <= instr_i;
    end
endmodule

// file: dv/test_board_reset_and_watchdog.sv
/*
 Testbench for the board reset and watchdog block.
 Assumes short timing parameters and the partner model on the pins.
*/
`timescale 1ns/100ps
`include "brw_defines.svh"
module test_board_reset_and_watchdog;
    import brw_pkg::*;
    localparam int WD_CYC = 200;
    logic mclk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic power_good_i = 1'b1;
    logic press = 1'b0;
    logic instr = 1'b0;
    logic [3:0] addr_i = 4'h0;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic reset_button_n_i, cpu_reset_instr_i, cpu_core_rst_o, computer_board_rst_o;
    logic line_modem_board_rst_o, radio_board_rst_o, status_led_o, wd_alarm_led_o;
    logic watchdog_status_flag_o, irq_o;
    logic [7:0] rdata_o;
    logic [7:0] rv;
    logic [3:0] rst_vec;
    int n_mismatch = 0;
    int compares = 0;
    int i;
    assign rst_vec = {cpu_core_rst_o, computer_board_rst_o, line_modem_board_rst_o,
        radio_board_rst_o};
    initial begin
        forever #4 mclk_i = ~mclk_i;
    end
    brw_partner partner (.mclk_i(mclk_i), .press_i(press), .instr_i(instr),
        .reset_button_n_o(reset_button_n_i), .cpu_reset_instr_o(cpu_reset_instr_i));
    brw_top #(.WD_TIMEOUT_CYC(WD_CYC), .RST_HOLD_CYC(16), .WD_PULSE_CYC(4), .DEB_CYC(4)) uut (
        .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .power_good_i(power_good_i),
        .reset_button_n_i(reset_button_n_i), .cpu_reset_instr_i(cpu_reset_instr_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .cpu_core_rst_o(cpu_core_rst_o), .computer_board_rst_o(computer_board_rst_o),
        .line_modem_board_rst_o(line_modem_board_rst_o), .radio_board_rst_o(radio_board_rst_o),
        .status_led_o(status_led_o), .wd_alarm_led_o(wd_alarm_led_o),
        .watchdog_status_flag_o(watchdog_status_flag_o), .irq_o(irq_o));
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp, input logic [7:0] m);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1;
        rv = rdata_o;
        check("register read", rv & m, exp);
        @(posedge mclk_i);
        #1;
        check("read data idle", rdata_o, 8'h00);
    endtask
    task automatic wait_board();
        for (i = 0; i < 300 && computer_board_rst_o !== 1'b0; i++) cyc(1);
        check("reset outputs released", 8'(rst_vec), 8'h00);
    endtask
    task automatic give_verdict();
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge mclk_i);
        n_mismatch++;
        give_verdict();
    end
    initial begin
        repeat (12) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        wait_board();
        rd_chk(`BRW_ADDR_CTRL, 8'(`BRW_CTRL_RST), 8'hff);
        rd_chk(`BRW_ADDR_IRQ_MASK, 8'(`BRW_IRQ_MASK_RST), 8'hff);
        wr(4'hf, 8'hff);
        rd_chk(4'hf, 8'h00, 8'hff);
        wr(`BRW_ADDR_IRQ_STAT, 8'h0f);
        wr(`BRW_ADDR_CTRL, 8'h01);
        cyc(2);
        check("yellow on", 8'(status_led_o), 8'h01);
        wr(`BRW_ADDR_CTRL, 8'h00);
        cyc(2);
        check("yellow off", 8'(status_led_o), 8'h00);
        @(posedge mclk_i);
        instr <= 1'b1;
        cyc(3);
        instr <= 1'b0;
        cyc(4);
        check("instr resets", 8'(rst_vec), 8'h07);
        wait_board();
        rd_chk(`BRW_ADDR_IRQ_STAT, 8'h08, 8'hff);
        check("irq masked", 8'(irq_o), 8'h00);
        wr(`BRW_ADDR_IRQ_MASK, 8'h08);
        cyc(2);
        check("irq raised", 8'(irq_o), 8'h01);
        wr(`BRW_ADDR_IRQ_STAT, 8'h08);
        cyc(2);
        check("irq cleared", 8'(irq_o), 8'h00);
        @(posedge mclk_i);
        press <= 1'b1;
        cyc(16);
        check("button resets", 8'(rst_vec), 8'h0f);
        press <= 1'b0;
        wait_board();
        wr(`BRW_ADDR_CTRL, 8'h03);
        repeat (3) begin
            cyc(150);
            wr(`BRW_ADDR_KICK, `BRW_KICK_KEY);
        end
        cyc(100);
        check("kicked no reset", 8'(rst_vec), 8'h00);
        wr(`BRW_ADDR_KICK, 8'h5a);
        for (i = 0; i < 300 && watchdog_status_flag_o !== 1'b1; i++) cyc(1);
        check("expiry time", 8'(i >= WD_CYC - 110 && i <= WD_CYC - 90), 8'h01);
        cyc(3);
        check("red on", 8'(wd_alarm_led_o), 8'h01);
        check("wd reset", 8'(rst_vec), 8'h0f);
        wait_board();
        rd_chk(`BRW_ADDR_STATUS, 8'h09, 8'h0f);
        wr(`BRW_ADDR_STATUS, 8'h01);
        cyc(2);
        check("red cleared", 8'(wd_alarm_led_o), 8'h00);
        @(posedge mclk_i);
        power_good_i <= 1'b0;
        cyc(6);
        check("drop resets", 8'(rst_vec), 8'h0f);
        @(posedge mclk_i);
        power_good_i <= 1'b1;
        wait_board();
        rd_chk(`BRW_ADDR_IRQ_STAT, 8'h07, 8'hff);
        give_verdict();
    end
endmodule
